//--- ccd_front_end_sample_output_path_tb.sv
// Self-checking bench for the sample output path
`timescale 1ns/1ns
module ccd_front_end_sample_output_path_tb;
    import front_end_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, start, dummy;
    logic        referenceSampleStrobe, dataSampleStrobe, samplerModeSelect, dummyPixelClamp_n;
    logic        blackPixelWindow, pixelValid, pixelOdd, inputClampEnable, launchDelaySelect;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [13:0] adc, refLvl, dataLvl;
    logic [11:0] pixelData;
    int          fails, cmp_count, cycles, k;
    int          g[4] = '{64, 1023, 64, 128};
    int          t[4] = '{80, 255, 80, 0};
    int          r[4] = '{1000, 9000, 1000, 1400};
    int          d[4] = '{998, 5000, 3000, 1000};
    sample_output_path i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .referenceSampleStrobe, .dataSampleStrobe, .samplerModeSelect, .dummyPixelClamp_n,
        .blackPixelWindow, .adcEven(adc), .adcOdd(adc), .pixelData, .pixelValid, .pixelOdd,
        .inputClampEnable, .launchDelaySelect);
    sensor_timing_model i_model (.clock, .start, .doubleSampling(samplerModeSelect), .dummy, .refLevel(refLvl),
        .dataLevel(dataLvl), .refStrobe(referenceSampleStrobe), .dataStrobe(dataSampleStrobe),
        .clampN(dummyPixelClamp_n), .adc);
    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] dt, output logic [31:0] rv, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dt;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next setup never reassigns psel in this step
        @(posedge clock);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] dt);
        logic [31:0] rv;
        logic        e;
        apb(1'b1, a, dt, rv, e);
        check(e, 32'h0);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] rv;
        logic        e;
        apb(1'b0, a, 32'h0, rv, e);
        check(rv, exp);
        check(e, expErr);
    endtask : rd
    function automatic logic [11:0] expWord(input int diff, input int gain, input int target);
        int v;
        v = ((diff * gain + 128) >>> 8) + 2 * target;
        v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
        return 12'(v);
    endfunction : expWord
    task pixel(input logic dm, input logic [13:0] rl, input logic [13:0] dl, input logic [11:0] exp);
        logic        seen, clampSeen;
        logic [11:0] w;
        dummy <= dm;
        refLvl <= rl;
        dataLvl <= dl;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        seen = 1'b0;
        clampSeen = 1'b0;
        repeat (22)
        begin
            @(posedge clock);
            if (pixelValid === 1'b1)
            begin
                seen = 1'b1;
                w = pixelData;
            end
            if (inputClampEnable === 1'b1)
                clampSeen = 1'b1;
        end
        check(seen, 32'h1);
        check(w, exp);
        check(clampSeen, dm);
    endtask : pixel
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        // Whole run needs well under a thousand cycles
        if (cycles > 5000)
        begin
            fails++;
            finish_test();
        end
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, start, dummy, blackPixelWindow} = 7'h00;
        samplerModeSelect = 1'b1;
        {paddr, pwdata, refLvl, dataLvl} = 68'h0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(GAIN_ADDR, 32'(GAIN_RESET), 1'b0);
        rd(BLACK_TARGET_ADDR, 32'(BLACK_TARGET_RESET), 1'b0);
        rd(POLARITY_ADDR, 32'(POLARITY_RESET), 1'b0);
        rd(CONFIG_ADDR, 32'(CONFIG_RESET), 1'b0);
        rd(8'h1C, 32'h0, 1'b1);
        wr(CONFIG_ADDR, 32'h1);
        @(posedge clock);
        check(launchDelaySelect, 32'h1);
        rd(CONFIG_ADDR, 32'h1, 1'b0);
        wr(CONFIG_ADDR, 32'h0);
        wr(EVEN_OFFSET_ADDR, 32'h123);
        rd(EVEN_OFFSET_ADDR, 32'h0, 1'b0);
        for (k = 0; k < 4; k++)
        begin
            wr(GAIN_ADDR, g[k]);
            wr(BLACK_TARGET_ADDR, t[k]);
            pixel(1'b0, r[k], d[k], expWord(r[k] - d[k], g[k], t[k]));
        end
        // Data strobe inverted until the reset below clears it
        wr(POLARITY_ADDR, 32'h2);
        rd(POLARITY_ADDR, 32'h2, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(GAIN_ADDR, 32'(GAIN_RESET), 1'b0);
        rd(POLARITY_ADDR, 32'(POLARITY_RESET), 1'b0);
        samplerModeSelect <= 1'b0;
        repeat (4) @(posedge clock);
        // Held clamp levels start at zero, so each channel's first dummy pixel saturates low
        pixel(1'b1, 14'h0, 14'd5000, 12'd0);
        pixel(1'b1, 14'h0, 14'd5000, 12'd0);
        pixel(1'b0, 14'h0, 14'd4600, 12'd260);
        samplerModeSelect <= 1'b1;
        blackPixelWindow <= 1'b1;
        repeat (4) @(posedge clock);
        pixel(1'b0, 14'd1400, 14'd1000, 12'd260);
        blackPixelWindow <= 1'b0;
        rd(EVEN_OFFSET_ADDR, 32'h0, 1'b0);
        rd(ODD_OFFSET_ADDR, 32'h1, 1'b0);
        finish_test();
    end
endmodule : ccd_front_end_sample_output_path_tb
bind sample_output_path sample_output_path_sva #(.LATENCY(LATENCY)) i_sva (.clock, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .referenceSampleStrobe, .dataSampleStrobe,
    .samplerModeSelect, .dummyPixelClamp_n, .pixelValid, .pixelOdd, .inputClampEnable, .launchDelaySelect);

//--- front_end_pkg.sv
// Constants shared by the dual-channel sensor front-end sample and output path
// Notes on behaviour
// - Even and odd channels share one processing path, with separate held levels and offsets
// - Round wide gain result to 12 bits
// - Even and odd words alternate on bus
// - Mode pin low: sample-hold, high: double sampling
// - Clamp only with clamp control and active strobe
// - Black offset servo updates only in window
// - Black output clamped to twice the register target code
// - Register selects output launch delay, 0 or 3ns
// - Gain and polarities come from registers; mode comes from the pin unless the register override bit is set
// - Reset returns every register to default
package front_end_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] GAIN_ADDR         = 8'h00;
    localparam logic [7:0] BLACK_TARGET_ADDR = 8'h04;
    localparam logic [7:0] POLARITY_ADDR     = 8'h08;
    localparam logic [7:0] CONFIG_ADDR       = 8'h0C;
    localparam logic [7:0] STATUS_ADDR       = 8'h10;
    localparam logic [7:0] EVEN_OFFSET_ADDR  = 8'h14;
    localparam logic [7:0] ODD_OFFSET_ADDR   = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int POL_REF_BIT      = 0;
    localparam int POL_DATA_BIT     = 1;
    localparam int POL_CLAMP_BIT    = 2;
    localparam int POL_WINDOW_BIT   = 3;
    localparam int CFG_DELAY_BIT    = 0;
    localparam int CFG_OVERRIDE_BIT = 1;
    localparam int CFG_MODE_BIT     = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [9:0] GAIN_RESET         = 10'h040;
    localparam logic [7:0] BLACK_TARGET_RESET = 8'h50;
    localparam logic [3:0] POLARITY_RESET     = 4'h0;
    localparam logic [2:0] CONFIG_RESET       = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Data path shape and timing
    localparam int ADC_WIDTH     = 14;
    localparam int OUT_WIDTH     = 12;
    localparam int GAIN_WIDTH    = 10;
    localparam int GAIN_FRAC     = 6;
    localparam int ROUND_SHIFT   = GAIN_FRAC + ADC_WIDTH - OUT_WIDTH;
    localparam int OFFSET_WIDTH  = 12;
    localparam int DATA_LATENCY  = 9;
    localparam int ARITH_STAGES  = 4;
    localparam int PIXEL_RATE_MHZ = 30;
    localparam int CLOCK_MHZ     = 125;

endpackage : front_end_pkg

//--- sample_output_path.sv
// Sample capture, gain, rounding, black-level servo and interleaved output of both channels
`timescale 1ns/1ns
module sample_output_path
#(
    parameter int ADC_BITS    = front_end_pkg::ADC_WIDTH,
    parameter int OUT_BITS    = front_end_pkg::OUT_WIDTH,
    parameter int LATENCY     = front_end_pkg::DATA_LATENCY
)
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                referenceSampleStrobe,
    input  wire logic                dataSampleStrobe,
    input  wire logic                samplerModeSelect,
    input  wire logic                dummyPixelClamp_n,
    input  wire logic                blackPixelWindow,
    input  wire logic [ADC_BITS-1:0] adcEven,
    input  wire logic [ADC_BITS-1:0] adcOdd,
    output logic      [OUT_BITS-1:0] pixelData,
    output logic                     pixelValid,
    output logic                     pixelOdd,
    output logic                     inputClampEnable,
    output logic                     launchDelaySelect
);
    import front_end_pkg::*;

    localparam int DIFF_BITS = ADC_BITS + 1;
    localparam int PROD_BITS = DIFF_BITS + GAIN_WIDTH + 1;
    localparam int TAIL      = LATENCY - ARITH_STAGES;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [GAIN_WIDTH-1:0] gain;
    logic [7:0]            blackTarget;
    logic [3:0]            polarity;
    logic [2:0]            control;

    logic signed [OFFSET_WIDTH-1:0] offset [2];

    logic setupRead;
    logic accessNow;
    assign accessNow = psel && penable && !pready;

    // Second access cycle completes the transfer so pready can come from a flop
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            pready <= 1'b0;
        else
            pready <= accessNow;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gain        <= GAIN_RESET;
            blackTarget <= BLACK_TARGET_RESET;
            polarity    <= POLARITY_RESET;
            control     <= CONFIG_RESET;
        end
        else if (accessNow && pwrite)
        begin
            if (paddr == GAIN_ADDR)
                gain <= pwdata[GAIN_WIDTH-1:0];
            else if (paddr == BLACK_TARGET_ADDR)
                blackTarget <= pwdata[7:0];
            else if (paddr == POLARITY_ADDR)
                polarity <= pwdata[3:0];
            else if (paddr == CONFIG_ADDR)
                control <= pwdata[2:0];
        end
    end

    logic activeModeDouble;
    logic [31:0] next_prdata;
    logic        next_slverr;

    always_comb
    begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        if (paddr == GAIN_ADDR)
            next_prdata[GAIN_WIDTH-1:0] = gain;
        else if (paddr == BLACK_TARGET_ADDR)
            next_prdata[7:0] = blackTarget;
        else if (paddr == POLARITY_ADDR)
            next_prdata[3:0] = polarity;
        else if (paddr == CONFIG_ADDR)
            next_prdata[2:0] = control;
        else if (paddr == STATUS_ADDR)
            next_prdata[2:0] = {inputClampEnable, pixelOdd, activeModeDouble};
        else if (paddr == EVEN_OFFSET_ADDR)
            next_prdata = {{(32-OFFSET_WIDTH){offset[0][OFFSET_WIDTH-1]}}, offset[0]};
        else if (paddr == ODD_OFFSET_ADDR)
            next_prdata = {{(32-OFFSET_WIDTH){offset[1][OFFSET_WIDTH-1]}}, offset[1]};
        else
            next_slverr = 1'b1;
    end

    assign setupRead = accessNow && !pwrite;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= setupRead ? next_prdata : 32'h00000000;
            pslverr <= accessNow && next_slverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; polarity applied only after the second flop
    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic [3:0] pinLevel;
    logic       modeMeta;
    logic       modeSync;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pinMeta  <= 4'h0;
            pinSync  <= 4'h0;
            modeMeta <= 1'b0;
            modeSync <= 1'b0;
        end
        else
        begin
            pinMeta  <= {blackPixelWindow, dummyPixelClamp_n, dataSampleStrobe, referenceSampleStrobe};
            pinSync  <= pinMeta;
            modeMeta <= samplerModeSelect;
            modeSync <= modeMeta;
        end
    end

    // Clamp pin is active low by default, so its sense flips after polarity
    assign pinLevel = (pinSync ^ polarity) ^ 4'h4;

    logic refLevel;
    logic dataLevel;
    logic clampLevel;
    logic windowLevel;
    assign refLevel    = pinLevel[POL_REF_BIT];
    assign dataLevel   = pinLevel[POL_DATA_BIT];
    assign clampLevel  = pinLevel[POL_CLAMP_BIT];
    assign windowLevel = pinLevel[POL_WINDOW_BIT];

    // Register override wins over the mode pin when enabled
    assign activeModeDouble = control[CFG_OVERRIDE_BIT] ? control[CFG_MODE_BIT] : modeSync;

    logic refLast;
    logic dataLast;
    logic refEdge;
    logic dataEdge;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            refLast  <= 1'b0;
            dataLast <= 1'b0;
        end
        else
        begin
            refLast  <= refLevel;
            dataLast <= dataLevel;
        end
    end

    assign refEdge  = refLevel && !refLast;
    assign dataEdge = dataLevel && !dataLast;

    ////////////////////////////////////////////////////////////////////////////
    // Clamp gating: clamp control and the mode's active strobe together
    logic activeStrobe;
    assign activeStrobe = activeModeDouble ? refLevel : dataLevel;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            inputClampEnable <= 1'b0;
        else
            inputClampEnable <= clampLevel && activeStrobe;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            launchDelaySelect <= 1'b0;
        else
            launchDelaySelect <= control[CFG_DELAY_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample capture; pixels alternate even then odd on each data strobe
    logic                channel;
    logic [ADC_BITS-1:0] refSample [2];
    logic [ADC_BITS-1:0] clampHeld [2];
    logic [ADC_BITS-1:0] adcNow;
    assign adcNow = channel ? adcOdd : adcEven;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            channel <= 1'b0;
        else if (dataEdge)
            channel <= !channel;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            refSample[0] <= '0;
            refSample[1] <= '0;
        end
        else if (refEdge)
            refSample[channel] <= adcNow;
    end

    // Sample-hold reference is the level seen while the input is clamped
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            clampHeld[0] <= '0;
            clampHeld[1] <= '0;
        end
        else if (dataEdge && clampLevel && !activeModeDouble)
            clampHeld[channel] <= adcNow;
    end

    logic                         s1Valid;
    logic                         s1Odd;
    logic                         s1Window;
    logic signed [DIFF_BITS-1:0]  s1Diff;
    logic [ADC_BITS-1:0]          baseLevel;
    assign baseLevel = activeModeDouble ? refSample[channel] : clampHeld[channel];

    // Signal level falls below the reference, so reference minus data is positive
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s1Valid  <= 1'b0;
            s1Odd    <= 1'b0;
            s1Window <= 1'b0;
            s1Diff   <= '0;
        end
        else
        begin
            s1Valid  <= dataEdge;
            s1Odd    <= channel;
            s1Window <= windowLevel;
            s1Diff   <= $signed({1'b0, baseLevel}) - $signed({1'b0, adcNow});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset subtraction and per-channel black-level servo
    logic                        s2Valid;
    logic                        s2Odd;
    logic signed [DIFF_BITS-1:0] s2Corr;
    logic signed [DIFF_BITS-1:0] corrNow;
    assign corrNow = s1Diff - DIFF_BITS'(offset[s1Odd]);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s2Valid <= 1'b0;
            s2Odd   <= 1'b0;
            s2Corr  <= '0;
        end
        else
        begin
            s2Valid <= s1Valid;
            s2Odd   <= s1Odd;
            s2Corr  <= corrNow;
        end
    end

    // One step per black pixel keeps the servo slow and noise tolerant
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            offset[0] <= '0;
            offset[1] <= '0;
        end
        else if (s1Valid && s1Window)
        begin
            if (corrNow > 0 && offset[s1Odd] != {1'b0, {(OFFSET_WIDTH-1){1'b1}}})
                offset[s1Odd] <= offset[s1Odd] + 1'b1;
            else if (corrNow < 0 && offset[s1Odd] != {1'b1, {(OFFSET_WIDTH-1){1'b0}}})
                offset[s1Odd] <= offset[s1Odd] - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain, rounding, target code and saturation
    logic                        s3Valid;
    logic                        s3Odd;
    logic signed [PROD_BITS-1:0] s3Prod;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s3Valid <= 1'b0;
            s3Odd   <= 1'b0;
            s3Prod  <= '0;
        end
        else
        begin
            s3Valid <= s2Valid;
            s3Odd   <= s2Odd;
            // Operands widened first so the product is not cut to the operand width
            s3Prod  <= PROD_BITS'(s2Corr) * PROD_BITS'($signed({1'b0, gain}));
        end
    end

    logic signed [PROD_BITS-1:0] rounded;
    logic signed [PROD_BITS-1:0] withTarget;
    assign rounded    = (s3Prod + PROD_BITS'(1 << (ROUND_SHIFT - 1))) >>> ROUND_SHIFT;
    assign withTarget = rounded + PROD_BITS'({blackTarget, 1'b0});

    logic                s4Valid;
    logic                s4Odd;
    logic [OUT_BITS-1:0] s4Word;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s4Valid <= 1'b0;
            s4Odd   <= 1'b0;
            s4Word  <= '0;
        end
        else
        begin
            s4Valid <= s3Valid;
            s4Odd   <= s3Odd;
            if (withTarget < 0)
                s4Word <= '0;
            else if (withTarget > PROD_BITS'({OUT_BITS{1'b1}}))
                s4Word <= {OUT_BITS{1'b1}};
            else
                s4Word <= withTarget[OUT_BITS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay line pads the path to the fixed latency
    logic [OUT_BITS+1:0] tail [TAIL];

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < TAIL; i++)
                tail[i] <= '0;
        end
        else
        begin
            tail[0] <= {s4Valid, s4Odd, s4Word};
            for (int i = 1; i < TAIL; i++)
                tail[i] <= tail[i-1];
        end
    end

    // Outputs hold the last word between pixels
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pixelData  <= '0;
            pixelOdd   <= 1'b0;
            pixelValid <= 1'b0;
        end
        else
        begin
            pixelValid <= tail[TAIL-1][OUT_BITS+1];
            if (tail[TAIL-1][OUT_BITS+1])
            begin
                pixelData <= tail[TAIL-1][OUT_BITS-1:0];
                pixelOdd  <= tail[TAIL-1][OUT_BITS];
            end
        end
    end

endmodule : sample_output_path

//--- sample_output_path_sva.sv
// Checker on the APB side and the pixel stream of the sample output path
`timescale 1ns/1ns
module sample_output_path_sva
#(
    parameter int LATENCY = front_end_pkg::DATA_LATENCY
)
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        referenceSampleStrobe,
    input wire logic        dataSampleStrobe,
    input wire logic        samplerModeSelect,
    input wire logic        dummyPixelClamp_n,
    input wire logic        pixelValid,
    input wire logic        pixelOdd,
    input wire logic        inputClampEnable,
    input wire logic        launchDelaySelect
);
    import front_end_pkg::*;
    // Pin edge to word: two sync flops ahead of the pipeline and the output flop after it
    localparam int PIN_TO_WORD = LATENCY + 3;
    logic expOdd;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            expOdd <= 1'b0;
        else if (pixelValid)
            expOdd <= !expOdd;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    a_ready_late: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready |-> pslverr == !(paddr[1:0] == 2'b00 && paddr <= ODD_OFFSET_ADDR))
        else $error("pslverr wrong for address");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero when idle");
    a_delay_copy: assert property (psel && penable && pready && pwrite && paddr == CONFIG_ADDR
        |=> launchDelaySelect == $past(pwdata[CFG_DELAY_BIT]))
        else $error("launch delay not taken from write");
    a_word_latency: assert property ($rose(dataSampleStrobe) |-> ##PIN_TO_WORD pixelValid)
        else $error("word not on time");
    a_odd_order: assert property (pixelValid |-> pixelOdd == expOdd)
        else $error("even and odd words out of turn");
    a_clamp_pin: assert property (dummyPixelClamp_n [*5] |-> !inputClampEnable)
        else $error("clamp with control released");
    a_clamp_strobe: assert property ((samplerModeSelect ? !referenceSampleStrobe : !dataSampleStrobe) [*5]
        |-> !inputClampEnable)
        else $error("clamp without active strobe");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !pready && !pslverr && !pixelValid
        && !inputClampEnable && !launchDelaySelect)
        else $error("outputs not cleared by reset");
    c_odd_word: cover property (pixelValid && pixelOdd);
    c_bad_addr: cover property (pready && pslverr);
    c_clamp: cover property (inputClampEnable);
endmodule : sample_output_path_sva

//--- sensor_timing_model.sv
// Behavioural sensor timing generator: strobes, clamp control and converter codes of one pixel
`timescale 1ns/1ns
module sensor_timing_model
(
    input  wire logic        clock,
    input  wire logic        start,
    input  wire logic        doubleSampling,
    input  wire logic        dummy,
    input  wire logic [13:0] refLevel,
    input  wire logic [13:0] dataLevel,
    output logic             refStrobe,
    output logic             dataStrobe,
    output logic             clampN,
    output logic      [13:0] adc
);
    logic [4:0] phase = 5'h00;
    always_ff @(posedge clock)
    begin
        if (start)
            phase <= 5'h01;
        else if (phase == 5'h14)
            phase <= 5'h00;
        else if (phase != 5'h00)
            phase <= phase + 5'h01;
    end
    // Reference strobe only in double sampling, always ahead of the data strobe
    assign refStrobe = doubleSampling && (phase == 5'h01 || phase == 5'h02);
    assign dataStrobe = (phase == 5'h06 || phase == 5'h07);
    assign clampN = !(dummy && phase != 5'h00);
    // Outside the sample windows the code is inverted so a stale capture shows
    assign adc = (phase >= 5'h01 && phase <= 5'h05) ? refLevel
               : (phase >= 5'h06 && phase <= 5'h0B) ? dataLevel : ~dataLevel;
endmodule : sensor_timing_model
